// *** core/serial_channel_pkg.sv ***
// Constants, field layouts and helper functions for the serial receive channel.
// Assumes one system clock; all line-side pins arrive asynchronously.

package serial_channel_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [3:0] ADDR_RX_CTRL = 4'h0;
	localparam logic [3:0] ADDR_MISC_MODE = 4'h1;
	localparam logic [3:0] ADDR_TX_SYNC = 4'h2;
	localparam logic [3:0] ADDR_RX_SYNC = 4'h3;
	localparam logic [3:0] ADDR_AUX = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h5;
	localparam logic [3:0] ADDR_DATA = 4'h6;
	localparam logic [3:0] ADDR_CMD = 4'h7;
	localparam logic [3:0] ADDR_CRC_LO = 4'h8;
	localparam logic [3:0] ADDR_CRC_HI = 4'h9;

	localparam logic [7:0] RX_CTRL_RST = 8'h00;
	localparam logic [7:0] MISC_MODE_RST = 8'h04;
	localparam logic [7:0] SYNC_RST = 8'h00;
	localparam logic [7:0] AUX_RST = 8'h00;
	localparam logic [7:0] FILL_PAD = 8'h00;
	localparam int CMD_CHAN_RESET = 0;
	localparam int CMD_ERR_RESET = 1;
	localparam int MISC_D2 = 2;

	// ----------------------------------------
	// Field codes
	// ----------------------------------------
	localparam logic [1:0] LEN_5 = 2'h0;
	localparam logic [1:0] LEN_7 = 2'h1;
	localparam logic [1:0] LEN_6 = 2'h2;
	localparam logic [1:0] LEN_8 = 2'h3;
	localparam logic [1:0] SYNC_MONO = 2'h0;
	localparam logic [1:0] SYNC_BI = 2'h1;
	localparam logic [1:0] SYNC_SDLC = 2'h2;
	localparam logic [1:0] SYNC_EXT = 2'h3;
	localparam logic [1:0] STOP_SYNC = 2'h0;
	localparam logic [1:0] STOP_ONE_HALF = 2'h2;
	localparam logic [1:0] CLK_1X = 2'h0;
	localparam logic [1:0] CLK_16X = 2'h1;
	localparam logic [1:0] CLK_32X = 2'h2;
	localparam logic [1:0] CLK_64X = 2'h3;
	localparam logic [6:0] DIV_1X = 7'h01;
	localparam logic [6:0] DIV_16X = 7'h10;
	localparam logic [6:0] DIV_32X = 7'h20;
	localparam logic [6:0] DIV_64X = 7'h40;
	localparam logic [3:0] SH_W = 4'h9;
	localparam logic [2:0] FLAG_ONES = 3'h5;
	localparam logic [2:0] ABORT_ONES = 3'h6;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [4:0] PIN_RST = 5'h1f;
	localparam int PIN_CLK = 4;
	localparam int PIN_DATA = 3;
	localparam int PIN_DCD = 2;
	localparam int PIN_CTS = 1;
	localparam int PIN_SYNC = 0;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic [1:0] char_len;
		logic auto_en;
		logic hunt;
		logic crc_en;
		logic addr_search;
		logic load_inhibit;
		logic rx_enable;
	} rx_ctrl_type;

	typedef struct packed {
		logic [1:0] clk_mode;
		logic [1:0] sync_mode;
		logic [1:0] stop;
		logic parity_even;
		logic parity_en;
	} misc_mode_type;

	typedef struct packed {
		logic [2:0] spare;
		logic tx_enable;
		logic local_loop;
		logic auto_echo;
		logic sync6;
		logic xtal_osc;
	} aux_type;

	typedef struct packed {
		logic config_err;
		logic parity_err;
		logic frame_err;
		logic overrun;
		logic cts;
		logic dcd;
		logic hunt;
		logic avail;
	} status_type;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_START = 4'b0010,
		ST_DATA = 4'b0100,
		ST_STOP = 4'b1000
	} rx_state_type;

	function automatic logic [3:0] char_bits(input logic [1:0] code);
		case (code)
			LEN_5: char_bits = 4'h5;
			LEN_7: char_bits = 4'h7;
			LEN_6: char_bits = 4'h6;
			default: char_bits = 4'h8;
		endcase
	endfunction : char_bits

	function automatic logic [6:0] div_of(input logic [1:0] code);
		case (code)
			CLK_1X: div_of = DIV_1X;
			CLK_16X: div_of = DIV_16X;
			CLK_32X: div_of = DIV_32X;
			default: div_of = DIV_64X;
		endcase
	endfunction : div_of

	// Bytes enter least significant bit first
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++)
		begin
			r = r[15] ^ d[i] ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
		end
		return r;
	endfunction : crc_byte

endpackage : serial_channel_pkg

// *** core/serial_channel_rx.sv ***
// Receive side and shared mode configuration of one serial channel.
// Assumes the line clock is slow next to clk_sys so every edge is seen.
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/100ps

module serial_channel_rx
	import serial_channel_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic rx_clk,
	input wire logic rx_data,
	input wire logic carrier_detect_n,
	input wire logic cts_n,
	input wire logic sync_n,
	output logic [7:0] reg_rdata_ff,
	output logic rx_gate_ff,
	output logic tx_gate_ff,
	output logic hunt_exit_ff,
	output logic [15:0] tx_fill_ff,
	output logic tx_fill_16_ff
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [4:0] pin_s1_ff;
	logic [4:0] pin_s2_ff;
	logic rclk_d_ff;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			pin_s1_ff <= PIN_RST;
			pin_s2_ff <= PIN_RST;
			rclk_d_ff <= 1'b1;
		end
		else
		begin
			pin_s1_ff <= {rx_clk, rx_data, carrier_detect_n, cts_n, sync_n};
			pin_s2_ff <= pin_s1_ff;
			rclk_d_ff <= pin_s2_ff[PIN_CLK];
		end
	end

	logic din;
	logic rclk_edge;
	assign din = pin_s2_ff[PIN_DATA];
	assign rclk_edge = pin_s2_ff[PIN_CLK] & ~rclk_d_ff;

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	rx_ctrl_type rx_ctrl_ff;
	misc_mode_type misc_ff;
	aux_type aux_ff;
	logic [7:0] tx_sync_ff;
	logic [7:0] rx_sync_ff;
	logic chan_reset;
	logic err_reset;
	logic hunt_cmd;

	assign chan_reset = reg_wr && reg_addr == ADDR_CMD && reg_wdata[CMD_CHAN_RESET];
	assign err_reset = reg_wr && reg_addr == ADDR_CMD && reg_wdata[CMD_ERR_RESET];
	// Hunt bit is a command; enabling the receiver also restarts the hunt
	assign hunt_cmd = reg_wr && reg_addr == ADDR_RX_CTRL
		&& (reg_wdata[4] || (reg_wdata[0] && !rx_ctrl_ff.rx_enable));

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || chan_reset)
		begin
			rx_ctrl_ff <= RX_CTRL_RST;
			misc_ff <= MISC_MODE_RST;
			aux_ff <= AUX_RST;
		end
		else if (reg_wr)
		begin
			if (reg_addr == ADDR_RX_CTRL)
				rx_ctrl_ff <= {reg_wdata[7:5], 1'b0, reg_wdata[3:0]};
			if (reg_addr == ADDR_MISC_MODE)
				misc_ff <= reg_wdata;
			if (reg_addr == ADDR_AUX)
				aux_ff <= {3'h0, reg_wdata[4:0]};
		end
	end

	// Sync characters survive a channel reset, like other pattern storage
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			tx_sync_ff <= SYNC_RST;
			rx_sync_ff <= SYNC_RST;
		end
		else if (reg_wr && reg_addr == ADDR_TX_SYNC)
			tx_sync_ff <= reg_wdata;
		else if (reg_wr && reg_addr == ADDR_RX_SYNC)
			rx_sync_ff <= reg_wdata;
	end

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	logic is_sync;
	logic is_ext;
	logic is_bi;
	logic is_sdlc;
	logic rx_on;
	logic [6:0] div;
	logic [3:0] len;
	logic [3:0] total;

	assign is_sync = misc_ff.stop == STOP_SYNC;
	assign is_ext = is_sync && misc_ff.sync_mode == SYNC_EXT;
	assign is_bi = is_sync && misc_ff.sync_mode == SYNC_BI;
	assign is_sdlc = is_sync && (misc_ff.sync_mode == SYNC_SDLC
		|| (is_ext && misc_ff.clk_mode == CLK_64X));
	assign div = (!is_sync || is_ext) ? div_of(misc_ff.clk_mode) : DIV_1X;
	assign len = char_bits(rx_ctrl_ff.char_len);
	assign total = len + {3'h0, misc_ff.parity_en && !is_sync};
	// Carrier loss stops the receiver only when auto enables are on
	assign rx_on = rx_ctrl_ff.rx_enable
		&& !(rx_ctrl_ff.auto_en && pin_s2_ff[PIN_DCD] && !aux_ff.local_loop);

	// ----------------------------------------
	// Bit timing and framing
	// ----------------------------------------
	rx_state_type state_ff;
	logic [6:0] cnt_ff;
	logic start_det;
	logic bit_tick;

	assign start_det = rclk_edge && !is_sync && state_ff == ST_IDLE && !din;
	assign bit_tick = rx_on && rclk_edge && cnt_ff == 7'h00 && (is_sync || state_ff != ST_IDLE);

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || !rx_on)
			cnt_ff <= 7'h00;
		else if (start_det)
			cnt_ff <= (div == DIV_1X) ? 7'h00 : (div >> 1) - DIV_1X;
		else if (rclk_edge)
			cnt_ff <= (cnt_ff == 7'h00) ? div - DIV_1X : cnt_ff - DIV_1X;
	end

	logic [8:0] sh_ff;
	logic [3:0] bit_cnt_ff;
	logic [8:0] sh_nxt;
	assign sh_nxt = {din, sh_ff[8:1]};

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || !rx_on)
			state_ff <= ST_IDLE;
		else if (is_sync)
			state_ff <= ST_DATA;
		else
		begin
			unique case (state_ff)
				ST_IDLE: if (start_det) state_ff <= (div == DIV_1X) ? ST_DATA : ST_START;
				ST_START: if (bit_tick) state_ff <= din ? ST_IDLE : ST_DATA;
				ST_DATA: if (bit_tick && bit_cnt_ff + 4'h1 >= total) state_ff <= ST_STOP;
				ST_STOP: if (bit_tick) state_ff <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Hunt, zero deletion and assembly
	// ----------------------------------------
	logic hunt_ff;
	logic [15:0] hist_ff;
	logic [2:0] ones_ff;
	logic addr_phase_ff;
	logic rej_ff;
	logic [15:0] hist_nxt;
	logic mono_hit;
	logic ext_pin;
	logic sync_hit;
	logic flag_hit;
	logic abort_hit;
	logic zero_del;
	logic addr_miss;

	assign hist_nxt = {din, hist_ff[15:1]};
	assign mono_hit = aux_ff.sync6 ? hist_nxt[15:10] == rx_sync_ff[5:0] : hist_nxt[15:8] == rx_sync_ff;
	// Crystal option holds the internal sync signal active
	assign ext_pin = !pin_s2_ff[PIN_SYNC] || aux_ff.xtal_osc;
	assign flag_hit = is_sdlc && (hist_nxt[15:8] == rx_sync_ff || (is_ext && ext_pin));
	assign abort_hit = is_sdlc && din && ones_ff == ABORT_ONES;
	assign zero_del = is_sdlc && !din && ones_ff == FLAG_ONES;

	always_comb
	begin
		if (is_sdlc)
			sync_hit = flag_hit;
		else if (is_ext)
			sync_hit = ext_pin || (misc_ff.clk_mode == CLK_32X && mono_hit);
		else if (is_bi)
			sync_hit = aux_ff.sync6 ? hist_nxt[15:4] == {rx_sync_ff[5:0], tx_sync_ff[5:0]}
				: hist_nxt == {rx_sync_ff, tx_sync_ff};
		else
			sync_hit = mono_hit;
	end

	logic sync_done;
	assign sync_done = is_sync && bit_tick && !hunt_ff && !abort_hit && !flag_hit && !zero_del
		&& bit_cnt_ff + 4'h1 >= len;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || chan_reset)
		begin
			hunt_ff <= 1'b1;
			sh_ff <= 9'h000;
			bit_cnt_ff <= 4'h0;
			hist_ff <= 16'h0000;
			ones_ff <= 3'h0;
			addr_phase_ff <= 1'b1;
			rej_ff <= 1'b0;
			hunt_exit_ff <= 1'b0;
		end
		else
		begin
			hunt_exit_ff <= 1'b0;
			if (!rx_on)
				bit_cnt_ff <= 4'h0;
			else if (is_sync && bit_tick)
			begin
				hist_ff <= hist_nxt;
				ones_ff <= !din ? 3'h0 : (ones_ff == ABORT_ONES) ? ABORT_ONES : ones_ff + 3'h1;
				if (hunt_ff)
				begin
					if (sync_hit)
					begin
						hunt_ff <= 1'b0;
						hunt_exit_ff <= 1'b1;
						bit_cnt_ff <= 4'h0;
						addr_phase_ff <= 1'b1;
						rej_ff <= 1'b0;
					end
				end
				else if (abort_hit)
					hunt_ff <= 1'b1;
				else if (flag_hit)
				begin
					bit_cnt_ff <= 4'h0;
					addr_phase_ff <= 1'b1;
					rej_ff <= 1'b0;
				end
				else if (!zero_del)
				begin
					sh_ff <= sh_nxt;
					bit_cnt_ff <= sync_done ? 4'h0 : bit_cnt_ff + 4'h1;
					if (sync_done && is_sdlc)
						addr_phase_ff <= 1'b0;
					if (sync_done && addr_miss)
						rej_ff <= 1'b1;
				end
			end
			else if (!is_sync && bit_tick)
			begin
				if (state_ff == ST_DATA)
				begin
					sh_ff <= sh_nxt;
					bit_cnt_ff <= bit_cnt_ff + 4'h1;
				end
				else if (state_ff == ST_STOP)
					bit_cnt_ff <= 4'h0;
			end
			if (hunt_cmd)
				hunt_ff <= 1'b1;
		end
	end

	// ----------------------------------------
	// Delivery, stripping and address check
	// ----------------------------------------
	logic async_done;
	logic [8:0] aligned;
	logic [7:0] deliv_byte;
	logic parity_bad;
	logic strip;
	logic accept;

	assign async_done = !is_sync && bit_tick && state_ff == ST_STOP;
	// Unused upper positions read as ones in async framing
	assign aligned = (sh_ff >> (SH_W - total)) | (9'h1ff << total);
	assign deliv_byte = is_sync ? sh_nxt[8:1] : aligned[7:0];
	assign parity_bad = misc_ff.parity_en
		&& ((^(sh_ff >> (SH_W - total))) == misc_ff.parity_even);
	assign strip = rx_ctrl_ff.load_inhibit && !is_sdlc && deliv_byte == tx_sync_ff
		&& !(is_bi && aux_ff.sync6);
	// Upper nibble compare gives sixteen matching stations
	assign addr_miss = is_sdlc && addr_phase_ff && rx_ctrl_ff.addr_search
		&& (rx_ctrl_ff.load_inhibit ? deliv_byte[7:4] != tx_sync_ff[7:4]
		: deliv_byte != tx_sync_ff);
	assign accept = (sync_done || async_done) && !strip && !addr_miss && !(is_sdlc && rej_ff);

	// ----------------------------------------
	// Receive CRC
	// ----------------------------------------
	logic [15:0] crc_ff;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || chan_reset || hunt_exit_ff || (is_sync && bit_tick && flag_hit))
			crc_ff <= CRC_INIT;
		else if (accept && is_sync && (is_sdlc || rx_ctrl_ff.crc_en))
			crc_ff <= crc_byte(crc_ff, deliv_byte);
	end

	// ----------------------------------------
	// Data and status; a set beats a clear in the same cycle
	// ----------------------------------------
	logic [7:0] rx_byte_ff;
	status_type st_ff;
	logic data_rd;
	assign data_rd = reg_rd && reg_addr == ADDR_DATA;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || chan_reset)
		begin
			rx_byte_ff <= 8'h00;
			st_ff <= '0;
		end
		else
		begin
			if (accept)
				rx_byte_ff <= deliv_byte;
			st_ff.avail <= accept || (st_ff.avail && !data_rd);
			st_ff.overrun <= (accept && st_ff.avail && !data_rd) || (st_ff.overrun && !err_reset);
			st_ff.frame_err <= (accept && async_done && !din) || (st_ff.frame_err && !err_reset);
			st_ff.parity_err <= (accept && async_done && parity_bad) || (st_ff.parity_err && !err_reset);
			st_ff.config_err <= misc_ff.stop == STOP_ONE_HALF && misc_ff.clk_mode == CLK_1X;
			st_ff.cts <= !pin_s2_ff[PIN_CTS];
			st_ff.dcd <= !pin_s2_ff[PIN_DCD];
			st_ff.hunt <= hunt_ff && is_sync;
		end
	end

	// ----------------------------------------
	// Gates and transmit fill
	// ----------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			rx_gate_ff <= 1'b0;
			tx_gate_ff <= 1'b0;
			tx_fill_ff <= 16'h0000;
			tx_fill_16_ff <= 1'b0;
		end
		else
		begin
			rx_gate_ff <= rx_on;
			tx_gate_ff <= aux_ff.tx_enable && !(rx_ctrl_ff.auto_en && pin_s2_ff[PIN_CTS]
				&& !aux_ff.local_loop && !aux_ff.auto_echo);
			tx_fill_ff <= is_bi ? {rx_sync_ff, tx_sync_ff}
				: {FILL_PAD, is_sdlc ? rx_sync_ff : tx_sync_ff};
			tx_fill_16_ff <= is_bi;
		end
	end

	// ----------------------------------------
	// Register read port
	// ----------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || !reg_rd)
			reg_rdata_ff <= 8'h00;
		else
		begin
			case (reg_addr)
				ADDR_STATUS: reg_rdata_ff <= st_ff;
				ADDR_DATA: reg_rdata_ff <= rx_byte_ff;
				ADDR_CRC_LO: reg_rdata_ff <= crc_ff[7:0];
				ADDR_CRC_HI: reg_rdata_ff <= crc_ff[15:8];
				default: reg_rdata_ff <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_pad_ones;
		@(posedge clk_sys) disable iff (sys_rst)
		accept && !is_sync && rx_ctrl_ff.char_len == LEN_5 && !misc_ff.parity_en |=> rx_byte_ff[7:5] == 3'h7;
	endproperty
	a_pad_ones: assert property (p_pad_ones) else $error("async pad not ones");

	property p_dcd_gate;
		@(posedge clk_sys) disable iff (sys_rst)
		rx_ctrl_ff.auto_en && pin_s2_ff[PIN_DCD] && !aux_ff.local_loop |=> !rx_gate_ff;
	endproperty
	a_dcd_gate: assert property (p_dcd_gate) else $error("receiver open without carrier");

	property p_cts_free;
		@(posedge clk_sys) disable iff (sys_rst)
		aux_ff.tx_enable && !rx_ctrl_ff.auto_en |=> tx_gate_ff;
	endproperty
	a_cts_free: assert property (p_cts_free) else $error("transmit gated without auto enables");

	property p_hunt_exit;
		@(posedge clk_sys) disable iff (sys_rst)
		rx_on && is_sync && bit_tick && hunt_ff && sync_hit && !hunt_cmd && !chan_reset
		|=> !hunt_ff && hunt_exit_ff ##1 st_ff.hunt == 1'b0;
	endproperty
	a_hunt_exit: assert property (p_hunt_exit) else $error("hunt not left on match");

	property p_chan_reset;
		@(posedge clk_sys) disable iff (sys_rst)
		chan_reset |=> !rx_ctrl_ff.rx_enable && misc_ff[MISC_D2] ##1 !rx_gate_ff;
	endproperty
	a_chan_reset: assert property (p_chan_reset) else $error("reset left receiver or D2 wrong");

	property p_strip;
		@(posedge clk_sys) disable iff (sys_rst)
		(sync_done || async_done) && strip |=> $stable(rx_byte_ff) && $stable(crc_ff);
	endproperty
	a_strip: assert property (p_strip) else $error("stripped byte delivered");

	property p_addr_reject;
		@(posedge clk_sys) disable iff (sys_rst)
		sync_done && addr_miss && !st_ff.avail |=> !st_ff.avail && rej_ff;
	endproperty
	a_addr_reject: assert property (p_addr_reject) else $error("foreign address accepted");

	property p_ratio;
		@(posedge clk_sys) disable iff (sys_rst)
		is_sync && !is_ext |-> div == DIV_1X;
	endproperty
	a_ratio: assert property (p_ratio) else $error("sync mode not at 1X");

endmodule : serial_channel_rx

// *** dv/serial_station.sv ***
// Remote serial station facing the receive side of one channel.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/100ps

module serial_station
(
	output logic rx_clk,
	output logic rx_data,
	output logic carrier_detect_n,
	output logic cts_n,
	output logic sync_n
);
	localparam int HALF_NS = 40;

	initial
	begin
		rx_clk = 1'b0;
		rx_data = 1'b1;
		carrier_detect_n = 1'b1;
		cts_n = 1'b1;
		sync_n = 1'b1;
	end

	// ----------------------------------------
	// Line traffic
	// ----------------------------------------
	// Clock only runs inside a frame; data moves while the clock is low
	task automatic shift(input logic [15:0] bits, input int n);
		for (int i = 0; i < n; i++)
		begin
			rx_data = bits[i];
			#HALF_NS;
			rx_clk = 1'b1;
			#HALF_NS;
			rx_clk = 1'b0;
		end
		rx_data = 1'b1;
	endtask : shift

	task automatic set_pins(input logic dcd_n, input logic cts_lvl_n, input logic sync_lvl_n);
		carrier_detect_n = dcd_n;
		cts_n = cts_lvl_n;
		sync_n = sync_lvl_n;
	endtask : set_pins

endmodule : serial_station

// *** dv/serial_channel_rx_and_mode_config_tb_top.sv ***
// Self-checking bench for the serial receive channel.
// Assumes a remote station model on the line side and host writes on the register port.
`timescale 1ns/100ps

module serial_channel_rx_and_mode_config_tb_top;
	import serial_channel_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [7:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic rx_clk, rx_data, carrier_detect_n, cts_n, sync_n;
	logic [7:0] reg_rdata_ff;
	logic rx_gate_ff, tx_gate_ff, hunt_exit_ff, tx_fill_16_ff;
	logic [15:0] tx_fill_ff;
	int error_cnt = 0;
	int comparisons = 0;
	int hunt_cnt = 0;
	int lens[4] = '{5, 7, 6, 8};
	logic [7:0] v, d;
	logic p;

	serial_channel_rx uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .rx_clk(rx_clk), .rx_data(rx_data),
		.carrier_detect_n(carrier_detect_n), .cts_n(cts_n), .sync_n(sync_n), .reg_rdata_ff(reg_rdata_ff),
		.rx_gate_ff(rx_gate_ff), .tx_gate_ff(tx_gate_ff), .hunt_exit_ff(hunt_exit_ff),
		.tx_fill_ff(tx_fill_ff), .tx_fill_16_ff(tx_fill_16_ff));

	serial_station station (.rx_clk(rx_clk), .rx_data(rx_data), .carrier_detect_n(carrier_detect_n),
		.cts_n(cts_n), .sync_n(sync_n));

	initial
	begin
		forever #5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys)
	begin
		if (hunt_exit_ff === 1'b1)
			hunt_cnt++;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input logic [16:0] seen, input logic [16:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [3:0] a, input logic [7:0] dat);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= dat;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [7:0] q);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		q = reg_rdata_ff;
	endtask : rd

	function automatic logic par_of(input logic [7:0] x, input int n, input logic even);
		logic r;
		r = ~even;
		for (int i = 0; i < n; i++)
			r ^= x[i];
		return r;
	endfunction : par_of

	function automatic logic [7:0] exp_async(input logic [7:0] x, input int n, input logic pe, input logic pb);
		logic [7:0] r;
		r = 8'hff;
		for (int i = 0; i < n; i++)
			r[i] = x[i];
		if (pe && n < 8)
			r[n] = pb;
		return r;
	endfunction : exp_async

	// Start bit, data, optional parity, one stop bit
	task automatic send_async(input logic [7:0] x, input int n, input logic pe, input logic pb);
		logic [15:0] f;
		f = 16'hffff;
		f[0] = 1'b0;
		for (int i = 0; i < n; i++)
			f[i + 1] = x[i];
		if (pe)
			f[n + 1] = pb;
		station.shift(f, n + (pe ? 3 : 2));
		repeat (8) @(posedge clk_sys);
	endtask : send_async

	task automatic settle();
		repeat (8) @(posedge clk_sys);
	endtask : settle

	task automatic test_done();
		$display("mismatches %0d, comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done

	initial
	begin
		#500000;
		error_cnt++;
		test_done();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		void'($urandom(4190));
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		settle();
		check(rx_gate_ff, 1'b0);
		// Reset leaves misc mode async, one stop bit
		for (int c = 0; c < 4; c++)
		begin
			d = $urandom;
			wr(ADDR_RX_CTRL, {c[1:0], 6'h01});
			send_async(d, lens[c], 1'b0, 1'b0);
			rd(ADDR_DATA, v);
			check(v, exp_async(d, lens[c], 1'b0, 1'b0));
		end
		for (int ev = 0; ev < 2; ev++)
		begin
			d = $urandom;
			wr(ADDR_MISC_MODE, {6'h01, ev[0], 1'b1});
			wr(ADDR_RX_CTRL, 8'h41);
			p = par_of(d, 7, ev[0]);
			send_async(d, 7, 1'b1, p);
			rd(ADDR_DATA, v);
			check(v, exp_async(d, 7, 1'b1, p));
			rd(ADDR_STATUS, v);
			check(v[6], 1'b0);
			send_async(d, 7, 1'b1, ~p);
			rd(ADDR_STATUS, v);
			check(v[6], 1'b1);
			rd(ADDR_DATA, v);
			wr(ADDR_CMD, 8'h02);
		end
		wr(ADDR_MISC_MODE, 8'h04);
		wr(ADDR_TX_SYNC, 8'ha5);
		wr(ADDR_RX_CTRL, 8'hc3);
		send_async(8'ha5, 8, 1'b0, 1'b0);
		rd(ADDR_STATUS, v);
		check(v[0], 1'b0);
		send_async(8'h5a, 8, 1'b0, 1'b0);
		rd(ADDR_DATA, v);
		check(v, 8'h5a);
		wr(ADDR_AUX, 8'h10);
		wr(ADDR_RX_CTRL, 8'h21);
		station.set_pins(1'b1, 1'b1, 1'b1);
		settle();
		check({rx_gate_ff, tx_gate_ff}, 2'b00);
		station.set_pins(1'b0, 1'b0, 1'b1);
		settle();
		check({rx_gate_ff, tx_gate_ff}, 2'b11);
		station.set_pins(1'b1, 1'b1, 1'b1);
		wr(ADDR_AUX, 8'h18);
		settle();
		check({rx_gate_ff, tx_gate_ff}, 2'b11);
		// Echo frees the transmitter only; carrier still gates the receiver
		wr(ADDR_AUX, 8'h14);
		settle();
		check({rx_gate_ff, tx_gate_ff}, 2'b01);
		wr(ADDR_AUX, 8'h10);
		wr(ADDR_RX_CTRL, 8'h01);
		settle();
		check({rx_gate_ff, tx_gate_ff}, 2'b11);
		wr(ADDR_TX_SYNC, 8'h3c);
		wr(ADDR_RX_SYNC, 8'h96);
		for (int m = 0; m < 4; m++)
		begin
			wr(ADDR_MISC_MODE, {2'b00, m[1:0], 4'h0});
			settle();
			check({tx_fill_16_ff, tx_fill_ff}, m == 1 ? 17'h1963c : (m == 2 ? 17'h00096 : 17'h0003c));
		end
		// Monosync with a 16X field still runs at 1X
		wr(ADDR_MISC_MODE, 8'h40);
		wr(ADDR_RX_CTRL, 8'hd1);
		hunt_cnt = 0;
		station.shift(16'h0096, 8);
		settle();
		check(hunt_cnt == 1, 1'b1);
		wr(ADDR_MISC_MODE, 8'h30);
		wr(ADDR_RX_CTRL, 8'hd1);
		hunt_cnt = 0;
		station.set_pins(1'b1, 1'b1, 1'b0);
		station.shift(16'h0000, 2);
		station.set_pins(1'b1, 1'b1, 1'b1);
		settle();
		check(hunt_cnt != 0, 1'b1);
		// Frame with flag, station address and one data byte
		wr(ADDR_RX_SYNC, 8'h7e);
		wr(ADDR_TX_SYNC, 8'h42);
		wr(ADDR_MISC_MODE, 8'h20);
		wr(ADDR_RX_CTRL, 8'hd5);
		station.shift(16'h427e, 16);
		settle();
		rd(ADDR_DATA, v);
		check(v, 8'h42);
		station.shift(16'h005a, 8);
		settle();
		rd(ADDR_DATA, v);
		check(v, 8'h5a);
		// Foreign address: neither it nor its data may arrive
		station.shift(16'h997e, 16);
		station.shift(16'h0033, 8);
		settle();
		rd(ADDR_STATUS, v);
		check(v[0], 1'b0);
		wr(ADDR_RX_CTRL, 8'hc7);
		station.shift(16'h4f7e, 16);
		settle();
		rd(ADDR_DATA, v);
		check(v, 8'h4f);
		wr(ADDR_CMD, 8'h01);
		settle();
		check({rx_gate_ff, tx_gate_ff}, 2'b00);
		d = $urandom;
		wr(ADDR_RX_CTRL, 8'hc1);
		send_async(d, 8, 1'b0, 1'b0);
		rd(ADDR_DATA, v);
		check(v, d);
		wr(ADDR_MISC_MODE, 8'h08);
		settle();
		rd(ADDR_STATUS, v);
		check(v[7], 1'b1);
		test_done();
	end

endmodule : serial_channel_rx_and_mode_config_tb_top
